// [core/oss_consts.vh]
// Purpose: Shared constants of the octal switch serial control block
// Assumes: Included by bare name from the design files
// Notes: Definitions only
`ifndef OSS_CONSTS_VH
`define OSS_CONSTS_VH
// ****************************************
// Widths and reset values
// ****************************************
`define OSS_NCH 8
`define OSS_NPAR 4
`define OSS_LATCH_RST 8'h00
`define OSS_SHIFT_RST 8'h00
`define OSS_DIAG_RST 8'h00
// ****************************************
// Thermal restart timing
// ****************************************
`define OSS_CLK_NS 100
`define OSS_OT_OFF_US 1000
`define OSS_OT_ON_US 100
`define OSS_OT_OFF_CYC ((`OSS_OT_OFF_US * 1000) / `OSS_CLK_NS)
`define OSS_OT_ON_CYC ((`OSS_OT_ON_US * 1000) / `OSS_CLK_NS)
`endif

// [core/oss_sync.v]
// Purpose: Two-stage synchroniser for a bus of asynchronous levels
// Assumes: Inputs come from pins outside the clk_sys domain
// Notes: First stage is read only by the second stage
`timescale 1ns/10ps
`default_nettype none
module oss_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input wire clk_sys, // System clock
  input wire rst, // Async reset, active high
  input wire ce, // Clock enable
  input wire [W-1:0] d_in, // Asynchronous levels
  output reg [W-1:0] q_ff // Synchronised levels
);
  reg [W-1:0] meta_ff;
  // Two flip-flops in series
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_ff <= RST_VAL;
      q_ff <= RST_VAL;
    end else if (ce) begin
      meta_ff <= d_in;
      q_ff <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// [core/oss_thermal.v]
// Purpose: Per-channel low duty restart cycle under overtemperature
// Assumes: ot_in is already synchronised to clk_sys
// Notes: Off phase then short on phase, repeated while hot
`timescale 1ns/10ps
`default_nettype none
`include "oss_consts.vh"
module oss_thermal #(
  parameter OFF_CYC = `OSS_OT_OFF_CYC,
  parameter ON_CYC = `OSS_OT_ON_CYC
) (
  input wire clk_sys, // System clock
  input wire rst, // Async reset, active high
  input wire ce, // Clock enable
  input wire ot_in, // Overtemperature of this channel
  output wire allow // High when channel may conduct
);
  reg [15:0] cnt_ff;
  reg [15:0] nxt_cnt;
  reg phase_on_ff;
  reg nxt_phase_on;
  // Count off and on phases while hot, idle otherwise
  always @* begin
    nxt_cnt = cnt_ff;
    nxt_phase_on = phase_on_ff;
    if (!ot_in) begin
      nxt_cnt = 16'h0000;
      nxt_phase_on = 1'b0;
    end else if (phase_on_ff ? (cnt_ff >= ON_CYC[15:0] - 16'h0001)
                             : (cnt_ff >= OFF_CYC[15:0] - 16'h0001)) begin
      nxt_cnt = 16'h0000;
      nxt_phase_on = ~phase_on_ff;
    end else begin
      nxt_cnt = cnt_ff + 16'h0001;
    end
  end
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_ff <= 16'h0000;
      phase_on_ff <= 1'b0;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
      phase_on_ff <= nxt_phase_on;
    end
  end
  assign allow = ~ot_in | phase_on_ff;
endmodule
`default_nettype wire

// [core/oss_top.v]
// Purpose: Serial control and diagnosis of an eight channel low side switch
// Assumes: SPI master keeps sclk low at cs_n edges and respects lead time
// Notes: Pins are sampled by clk_sys; sclk edges found from samples
`timescale 1ns/10ps
`default_nettype none
`include "oss_consts.vh"
module oss_top #(
  parameter NCH = `OSS_NCH,
  parameter OT_OFF_CYC = `OSS_OT_OFF_CYC,
  parameter OT_ON_CYC = `OSS_OT_ON_CYC
) (
  input wire clk_sys, // System clock, 10 MHz
  input wire rst, // Async reset, active high
  input wire ce, // Clock enable, freezes state when low
  input wire reset_pin_n, // Reset pin, active low
  input wire cs_n, // Chip select pin, active low
  input wire sclk, // Serial clock pin
  input wire si, // Serial data in pin
  input wire [3:0] par_in, // Parallel inputs channels one to four
  input wire [7:0] overload_in, // Per-channel overload or short to supply
  input wire [7:0] open_load_in, // Per-channel open load or short to ground
  input wire [7:0] overtemp_in, // Per-channel overtemperature
  output reg so_o, // Serial data out level
  output reg so_oe_n, // Serial out enable, low drives
  output reg fault_o, // Fault pin level, always low when driven
  output reg fault_oe_n, // Fault pin enable, low pulls low
  output reg [7:0] chan_on // Channel gate drive, one is on
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  wire [2:0] spi_s;
  wire [4:0] ctl_s;
  wire [7:0] ovl_s;
  wire [7:0] opl_s;
  wire [7:0] ot_s;
  oss_sync #(.W(3), .RST_VAL(3'h4)) u_sync_spi (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .d_in({cs_n, sclk, si}),
    .q_ff(spi_s)
  );
  oss_sync #(.W(5), .RST_VAL(5'h00)) u_sync_ctl (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .d_in({reset_pin_n, par_in}),
    .q_ff(ctl_s)
  );
  oss_sync #(.W(24), .RST_VAL(24'h000000)) u_sync_flt (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .d_in({overload_in, open_load_in, overtemp_in}),
    .q_ff({ovl_s, opl_s, ot_s})
  );
  wire cs_s = spi_s[2];
  wire sclk_s = spi_s[1];
  wire si_s = spi_s[0];
  wire rstp_n_s = ctl_s[4];
  wire [3:0] par_s = ctl_s[3:0];
  // ****************************************
  // Edge detection
  // ****************************************
  reg cs_d_ff;
  reg sclk_d_ff;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cs_d_ff <= 1'b1;
      sclk_d_ff <= 1'b0;
    end else if (ce) begin
      cs_d_ff <= cs_s;
      sclk_d_ff <= sclk_s;
    end
  end
  wire cs_fall = cs_d_ff & ~cs_s;
  wire cs_rise = ~cs_d_ff & cs_s;
  wire sel = ~cs_s & ~cs_d_ff;
  wire sclk_fall = sel & sclk_d_ff & ~sclk_s;
  wire sclk_rise = sel & ~sclk_d_ff & sclk_s;
  // ****************************************
  // Fault detection and diagnosis register
  // ****************************************
  reg [7:0] latch_ff;
  reg [7:0] diag_ff;
  reg [7:0] nxt_diag;
  wire [7:0] fault_now;
  wire [7:0] cmd_on;
  wire cs_rise_ok;
  // Live fault: overload while commanded on, open load while off, or overtemperature
  assign fault_now = (ovl_s & cmd_on) | (opl_s & ~cmd_on) | ot_s;
  // Diagnosis sticky bits; a new fault wins over the cs rise clear
  always @* begin
    nxt_diag = diag_ff | fault_now;
    if (cs_rise_ok) begin
      nxt_diag = fault_now;
    end
  end
  // ****************************************
  // Shift register and transfer control
  // ****************************************
  reg [7:0] shift_ff;
  reg [7:0] nxt_shift;
  reg [7:0] nxt_latch;
  reg got_clk_ff;
  reg nxt_got_clk;
  reg so_bit_ff;
  reg nxt_so_bit;
  assign cs_rise_ok = cs_rise & got_clk_ff;
  // Capture, shift and transfer
  always @* begin
    nxt_shift = shift_ff;
    nxt_latch = latch_ff;
    nxt_got_clk = got_clk_ff;
    nxt_so_bit = so_bit_ff;
    if (cs_fall) begin
      // Diag bit is command bit, inverted where faulty
      nxt_shift = latch_ff ^ diag_ff;
      nxt_so_bit = latch_ff[7] ^ diag_ff[7];
      nxt_got_clk = 1'b0;
    end else if (sclk_fall) begin
      nxt_shift = {shift_ff[6:0], si_s};
      nxt_got_clk = 1'b1;
    end else if (sclk_rise) begin
      nxt_so_bit = shift_ff[7];
    end else if (cs_rise_ok) begin
      nxt_latch = shift_ff;
      nxt_got_clk = 1'b0;
    end
  end
  // State registers; reset pin clears shift and latches
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shift_ff <= `OSS_SHIFT_RST;
      latch_ff <= `OSS_LATCH_RST;
      diag_ff <= `OSS_DIAG_RST;
      got_clk_ff <= 1'b0;
      so_bit_ff <= 1'b0;
    end else if (ce) begin
      if (!rstp_n_s) begin
        shift_ff <= `OSS_SHIFT_RST;
        latch_ff <= `OSS_LATCH_RST;
        diag_ff <= `OSS_DIAG_RST;
        got_clk_ff <= 1'b0;
        so_bit_ff <= 1'b0;
      end else begin
        shift_ff <= nxt_shift;
        latch_ff <= nxt_latch;
        diag_ff <= nxt_diag;
        got_clk_ff <= nxt_got_clk;
        so_bit_ff <= nxt_so_bit;
      end
    end
  end
  // ****************************************
  // Channel drive
  // ****************************************
  wire [7:0] ot_allow;
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ot
      oss_thermal #(.OFF_CYC(OT_OFF_CYC), .ON_CYC(OT_ON_CYC)) u_ot (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .ot_in(ot_s[g]),
        .allow(ot_allow[g])
      );
    end
  endgenerate
  // Parallel OR on low four, serial only on high four
  assign cmd_on = {latch_ff[7:4], latch_ff[3:0] | par_s};
  // Registered pin outputs
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      chan_on <= 8'h00;
      so_o <= 1'b0;
      so_oe_n <= 1'b1;
      fault_o <= 1'b0;
      fault_oe_n <= 1'b1;
    end else if (ce) begin
      chan_on <= rstp_n_s ? (cmd_on & ot_allow) : 8'h00;
      so_o <= nxt_so_bit;
      so_oe_n <= cs_s;
      fault_o <= 1'b0;
      fault_oe_n <= ~(|nxt_diag);
    end
  end
endmodule
`default_nettype wire

// [test/oss_top_sva.sv]
// Purpose: Port checks of the octal switch serial block
// Assumes: Pins are held for several clk_sys cycles, ce tied high
// Notes: Bound to oss_top at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module oss_top_sva (
  input wire clk_sys, // System clock
  input wire rst, // Async reset
  input wire reset_pin_n, // Reset pin
  input wire cs_n, // Chip select
  input wire sclk, // Serial clock
  input wire [3:0] par_in, // Parallel inputs
  input wire [7:0] overload_in, // Overload flags
  input wire [7:0] overtemp_in, // Overtemperature flags
  input wire so_o, // Serial out level
  input wire so_oe_n, // Serial out enable
  input wire fault_o, // Fault pin level
  input wire fault_oe_n, // Fault pin enable
  input wire [7:0] chan_on // Channel drive
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // ****************************************
  // Properties
  // ****************************************
  // Windows allow for the two-stage pin synchronisers
  property p_oe_hi; cs_n [*5] |-> so_oe_n; endproperty
  a_oe_hi: assert property (p_oe_hi) else $error("so driven while deselected");
  property p_oe_lo; (!cs_n) [*5] |-> !so_oe_n; endproperty
  a_oe_lo: assert property (p_oe_lo) else $error("so not driven while selected");
  property p_so_hold; (!cs_n && !sclk) [*8] |-> $stable(so_o); endproperty
  a_so_hold: assert property (p_so_hold) else $error("so moved without sclk rise");
  property p_hold;
    (cs_n && reset_pin_n && $stable(par_in) && overtemp_in == 8'h00) [*8] |-> $stable(chan_on);
  endproperty
  a_hold: assert property (p_hold) else $error("channels moved while deselected");
  property p_par;
    (par_in == 4'hf && reset_pin_n && overtemp_in[3:0] == 4'h0) [*6] |-> chan_on[3:0] == 4'hf;
  endproperty
  a_par: assert property (p_par) else $error("parallel input ignored");
  property p_rstpin; (!reset_pin_n) [*6] |-> chan_on == 8'h00; endproperty
  a_rstpin: assert property (p_rstpin) else $error("channels on under reset pin");
  // Overload only counts on a channel that conducts
  property p_flt;
    (|(overload_in & chan_on) && $stable(overload_in) && $stable(chan_on)) [*6] |-> !fault_oe_n;
  endproperty
  a_flt: assert property (p_flt) else $error("fault pin not pulled");
  property p_flvl; !fault_oe_n |-> !fault_o; endproperty
  a_flvl: assert property (p_flvl) else $error("fault pin driven high");
endmodule
bind oss_top oss_top_sva u_oss_top_sva (.clk_sys(clk_sys), .rst(rst), .reset_pin_n(reset_pin_n),
  .cs_n(cs_n), .sclk(sclk), .par_in(par_in), .overload_in(overload_in),
  .overtemp_in(overtemp_in), .so_o(so_o), .so_oe_n(so_oe_n), .fault_o(fault_o),
  .fault_oe_n(fault_oe_n), .chan_on(chan_on));
`default_nettype wire

// [test/oss_spi_master.sv]
// Purpose: Serial master model for the octal switch port
// Assumes: clk_sys period 100 ns, sclk period 800 ns
// Notes: Idle lines sit at their pull levels
`timescale 1ns/10ps
`default_nettype none
module oss_spi_master (
  input wire logic clk_sys, // System clock
  input wire logic so_o, // Serial out level
  input wire logic so_oe_n, // Serial out enable
  output logic cs_n, // Chip select
  output logic sclk, // Serial clock
  output logic si // Serial data
);
  // Pull-up on select, pull-down on clock and data
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end
  // ****************************************
  // Frame of n bits, MSB first, so read before each fall
  // ****************************************
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx,
                      output logic bad);
    rx = 16'h0000;
    bad = 1'b0;
    @(posedge clk_sys) cs_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    for (int i = n - 1; i >= 0; i--) begin
      si <= tx[i];
      sclk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      // Bit shown after the rise stands until the next rise
      rx = {rx[14:0], so_o};
      bad = bad | so_oe_n;
      sclk <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    repeat (10) @(posedge clk_sys);
    cs_n <= 1'b1;
    si <= 1'b0;
    repeat (5) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// [test/test_oss_top.sv]
// Purpose: Self-checking bench of the octal switch serial block
// Assumes: Thermal phases shortened to 20 and 4 cycles
// Notes: Random bytes and faults with fixed seed
`timescale 1ns/10ps
`default_nettype none
module test_oss_top;
  logic clk_sys, rst, reset_pin_n, cs_n, sclk, si, so_o, so_oe_n, fault_o, fault_oe_n, bad;
  logic [3:0] par_in;
  logic [7:0] overload_in, open_load_in, overtemp_in, chan_on, b, a, last;
  logic [15:0] rx;
  int mismatches, compares, flips;
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  oss_top #(.OT_OFF_CYC(20), .OT_ON_CYC(4)) u_oss_top (.clk_sys(clk_sys), .rst(rst),
    .ce(1'b1), .reset_pin_n(reset_pin_n), .cs_n(cs_n), .sclk(sclk), .si(si),
    .par_in(par_in), .overload_in(overload_in), .open_load_in(open_load_in),
    .overtemp_in(overtemp_in), .so_o(so_o), .so_oe_n(so_oe_n), .fault_o(fault_o),
    .fault_oe_n(fault_oe_n), .chan_on(chan_on));
  oss_spi_master u_oss_spi_master (.clk_sys(clk_sys), .so_o(so_o), .so_oe_n(so_oe_n),
    .cs_n(cs_n), .sclk(sclk), .si(si));
  // ****************************************
  // Compare, expectation and verdict
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Diagnostic bit flips from the serial bit on overload while on, open load while off
  function automatic logic [7:0] diag_of(input logic [7:0] cmd, par, ovl, opl);
    logic [7:0] on;
    on = cmd | par;
    return cmd ^ ((ovl & on) | (opl & ~on));
  endfunction
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    reset_pin_n = 1'b1;
    par_in = 4'h0;
    overload_in = 8'h00;
    open_load_in = 8'h00;
    overtemp_in = 8'h00;
    mismatches = 0;
    compares = 0;
    void'($urandom(32'h3cf6aa6f));
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    check(16'(chan_on), 16'h0000);
    // Same byte three times; the last frame reads clean diagnosis
    for (int k = 0; k < 12; k++) begin
      b = 8'($urandom);
      par_in <= 4'($urandom);
      overload_in <= 8'($urandom);
      open_load_in <= 8'($urandom);
      repeat (3) u_oss_spi_master.xfer(16'(b), 8, rx, bad);
      repeat (8) @(posedge clk_sys);
      check(16'(chan_on), 16'(b | {4'h0, par_in}));
      check(rx, 16'(diag_of(b, {4'h0, par_in}, overload_in, open_load_in)));
      check(16'(bad), 16'h0000);
    end
    // Frame without a clock pulse leaves the channels alone
    a = chan_on;
    u_oss_spi_master.xfer(16'h00ff, 0, rx, bad);
    repeat (8) @(posedge clk_sys);
    check(16'(chan_on), 16'(a));
    // Sixteen bit frame: last byte wins, first byte passes through
    par_in <= 4'h0;
    overload_in <= 8'h00;
    open_load_in <= 8'h00;
    a = 8'($urandom);
    b = 8'($urandom);
    u_oss_spi_master.xfer({a, b}, 16, rx, bad);
    u_oss_spi_master.xfer({a, 8'h80}, 16, rx, bad);
    repeat (8) @(posedge clk_sys);
    check(16'(chan_on), 16'h0080);
    check(16'(rx[7:0]), 16'(a));
    // Overheat on channel eight: it restarts, others stay off
    overtemp_in <= 8'h80;
    flips = 0;
    last = chan_on;
    repeat (120) begin
      @(posedge clk_sys);
      if (chan_on[7] !== last[7]) flips++;
      last = chan_on;
    end
    check(16'(flips >= 3), 16'h0001);
    check(16'(chan_on[6:0]), 16'h0000);
    check(16'(fault_oe_n), 16'h0000);
    // Reset pin turns every channel off; parallel drive returns after it
    overtemp_in <= 8'h00;
    reset_pin_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    check(16'(chan_on), 16'h0000);
    reset_pin_n <= 1'b1;
    par_in <= 4'hf;
    repeat (8) @(posedge clk_sys);
    check(16'(chan_on), 16'h000f);
    close_out();
  end
endmodule
`default_nettype wire
